// ===== core/sac_top.sv
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module sac_top #(
  parameter int unsigned CAL_CYCLES = sac_pkg::CAL_CYCLES_DEF
) (
  input wire logic hclk,                                   // Bus and core clock
  input wire logic hresetn,                                // Async reset, low
  input wire logic hsel,                                   // Slave select
  input wire logic [31:0] haddr,                           // Byte address
  input wire logic [1:0] htrans,                           // Transfer type
  input wire logic hwrite,                                 // Write when high
  input wire logic [2:0] hsize,                            // Transfer size
  input wire logic [31:0] hwdata,                          // Write data
  input wire logic hready,                                 // Bus ready
  output logic hreadyout,                                  // Slave ready
  output logic [31:0] hrdata,                              // Read data
  output logic hresp,                                      // Always OKAY
  input wire logic cal_pin,                                // Calibration pin
  input wire logic [sac_pkg::PHASES-1:0] ls_gate_cmd,      // Low-side commands
  input wire logic [sac_pkg::PHASES-1:0] hs_gate_cmd,      // High-side commands
  output logic [2*sac_pkg::PHASES-1:0] amp_gain,           // Gain code per phase
  output logic vref_div_bypass,                            // Reference divider off
  output logic lowside_ref_neg,                            // Monitor on negative pin
  output logic [sac_pkg::PHASES-1:0] amp_enable,           // Amplifier enables
  output logic [sac_pkg::PHASES-1:0] amp_in_short,         // Inputs shorted
  output logic [sac_pkg::PHASES-1:0] amp_load_disc,        // Load disconnected
  output logic [sac_pkg::PHASES-1:0] amp_pos_switch_node,  // Positive input source
  output logic [sac_pkg::PHASES-1:0] amp_trim_run          // Trim routine running
);

  localparam int NP = sac_pkg::PHASES;
  localparam logic [sac_pkg::CNT_W-1:0] CAL_CNT = sac_pkg::CNT_W'(CAL_CYCLES);

  // ==========================================================
  // Elaboration checks
  generate
    if (CAL_CYCLES < 1 || CAL_CYCLES > (2 ** sac_pkg::CNT_W) - 1) begin : g_bad_cal
      $error("CAL_CYCLES must be between 1 and 65535");
    end
  endgenerate

  // ==========================================================
  // Decode helper
  function automatic logic addr_is(input logic [sac_pkg::ADDR_W-1:0] a,
                                   input logic [sac_pkg::ADDR_W-1:0] off);
    addr_is = (a[sac_pkg::ADDR_W-1:2] == off[sac_pkg::ADDR_W-1:2]);
  endfunction

  // ==========================================================
  // Bus slave state
  logic wr_pend_reg, wr_pend_next;
  logic rd_pend_reg, rd_pend_next;
  logic [sac_pkg::ADDR_W-1:0] addr_reg, addr_next;
  logic ready_next;
  logic [31:0] rdata_next;
  logic [sac_pkg::CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [sac_pkg::CNT_W-1:0] tdrive_reg, tdrive_next;
  logic [31:0] status_word;
  logic take, word_ok;

  // ==========================================================
  // Per-phase results
  logic [1:0] gain_ph [NP];
  logic [NP-1:0] en_ph, short_ph, disc_ph, pos_ph, trun_ph, tdone_ph, win_ph;
  logic [NP-1:0] cal_req_ph;
  logic fet_mode, vref_next, lsref_next;
  logic [2*NP-1:0] gain_flat;

  // ==========================================================
  // Bus and register next values
  always_comb begin
    take = hsel && hready && htrans[1];
    // Narrow transfers are answered OKAY but change nothing
    word_ok = (hsize == sac_pkg::HSIZE_WORD);
    wr_pend_next = 1'b0;
    rd_pend_next = 1'b0;
    addr_next = addr_reg;
    ctrl_next = ctrl_reg;
    tdrive_next = tdrive_reg;
    ready_next = 1'b1;
    rdata_next = hrdata;
    if (wr_pend_reg) begin
      if (addr_is(addr_reg, sac_pkg::ADDR_CTRL)) begin
        ctrl_next = hwdata[sac_pkg::CTRL_W-1:0];
      end else if (addr_is(addr_reg, sac_pkg::ADDR_TDRIVE)) begin
        tdrive_next = hwdata[sac_pkg::CNT_W-1:0];
      end
    end
    // Read data comes one cycle after the wait state so a read
    // that follows a write sees the value just written
    if (rd_pend_reg) begin
      if (addr_is(addr_reg, sac_pkg::ADDR_CTRL)) begin
        rdata_next = {24'h000000, ctrl_reg};
      end else if (addr_is(addr_reg, sac_pkg::ADDR_TDRIVE)) begin
        rdata_next = {16'h0000, tdrive_reg};
      end else if (addr_is(addr_reg, sac_pkg::ADDR_STATUS)) begin
        rdata_next = status_word;
      end else begin
        rdata_next = sac_pkg::RDATA_ZERO;
      end
    end
    if (take) begin
      addr_next = haddr[sac_pkg::ADDR_W-1:0];
      wr_pend_next = hwrite && word_ok;
      rd_pend_next = !hwrite;
      ready_next = hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= '0;
      hreadyout <= 1'b1;
      hrdata <= sac_pkg::RDATA_ZERO;
      hresp <= 1'b0;
      ctrl_reg <= sac_pkg::CTRL_RST;
      tdrive_reg <= sac_pkg::TDRIVE_RST;
    end else begin
      wr_pend_reg <= wr_pend_next;
      rd_pend_reg <= rd_pend_next;
      addr_reg <= addr_next;
      hreadyout <= ready_next;
      hrdata <= rdata_next;
      hresp <= 1'b0;
      ctrl_reg <= ctrl_next;
      tdrive_reg <= tdrive_next;
    end
  end

  // ==========================================================
  // Mode decode
  always_comb begin
    fet_mode = ctrl_reg[sac_pkg::FET_BIT];
    // Pin requests all phases, register bits request their own
    cal_req_ph = ctrl_reg[sac_pkg::CAL_LSB +: NP] | {NP{cal_pin}};
    vref_next = ctrl_reg[sac_pkg::VREF_BYP_BIT];
    // Sensing across the transistor would blind the monitor on the
    // positive pin, so the reference bit is overridden
    if (fet_mode) begin
      lsref_next = 1'b1;
    end else begin
      lsref_next = ctrl_reg[sac_pkg::LSREF_BIT];
    end
    status_word = '0;
    status_word[sac_pkg::ST_TRIM_RUN_LSB +: NP] = trun_ph;
    status_word[sac_pkg::ST_TRIM_DONE_LSB +: NP] = tdone_ph;
    status_word[sac_pkg::ST_AMP_EN_LSB +: NP] = en_ph;
    status_word[sac_pkg::ST_WIN_LSB +: NP] = win_ph;
    status_word[sac_pkg::ST_SHORT_LSB +: NP] = short_ph;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vref_div_bypass <= 1'b0;
      lowside_ref_neg <= 1'b0;
    end else begin
      vref_div_bypass <= vref_next;
      lowside_ref_neg <= lsref_next;
    end
  end

  // ==========================================================
  // Phase controllers
  generate
    for (genvar p = 0; p < NP; p++) begin : g_ph
      sac_phase u_phase (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .ls_cmd        (ls_gate_cmd[p]),
        .hs_cmd        (hs_gate_cmd[p]),
        .drive_cycles  (tdrive_reg),
        .cal_cycles    (CAL_CNT),
        .fet_mode      (fet_mode),
        .cal_req       (cal_req_ph[p]),
        .gain_prog     (ctrl_reg[sac_pkg::GAIN_LSB +: 2]),
        .gain_eff      (gain_ph[p]),
        .amp_enable    (en_ph[p]),
        .in_short      (short_ph[p]),
        .load_disc     (disc_ph[p]),
        .pos_to_switch (pos_ph[p]),
        .trim_run      (trun_ph[p]),
        .trim_done     (tdone_ph[p]),
        .window_active (win_ph[p])
      );
      assign gain_flat[2*p +: 2] = gain_ph[p];
    end
  endgenerate

  // Phase outputs are flip-flops inside each controller
  assign amp_gain = gain_flat;
  assign amp_enable = en_ph;
  assign amp_in_short = short_ph;
  assign amp_load_disc = disc_ph;
  assign amp_pos_switch_node = pos_ph;
  assign amp_trim_run = trun_ph;

endmodule
`default_nettype wire

// ===== core/sac_pkg.sv
package sac_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_MHZ = 250;
  localparam int CAL_TIME_US = 100;
  // Longest time rounds down: whole cycles inside the trim budget
  localparam int CAL_CYCLES_DEF = CAL_TIME_US * CLK_MHZ;
  localparam int CNT_W = 16;

  // ==========================================================
  // Phases
  localparam int PHASES = 3;

  // ==========================================================
  // Register map (byte addresses, low two address bits ignored)
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_TDRIVE = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  // Control register fields
  localparam int CTRL_W = 8;
  localparam int GAIN_LSB = 0;
  localparam int VREF_BYP_BIT = 2;
  localparam int FET_BIT = 3;
  localparam int LSREF_BIT = 4;
  localparam int CAL_LSB = 5;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Drive window length in clock cycles
  localparam logic [15:0] TDRIVE_RST = 16'h03E8;

  // Status register fields
  localparam int ST_TRIM_RUN_LSB = 0;
  localparam int ST_TRIM_DONE_LSB = 3;
  localparam int ST_AMP_EN_LSB = 6;
  localparam int ST_WIN_LSB = 9;
  localparam int ST_SHORT_LSB = 12;

  // ==========================================================
  // Gain codes
  localparam logic [1:0] GAIN_5 = 2'h0;
  localparam logic [1:0] GAIN_10 = 2'h1;
  localparam logic [1:0] GAIN_20 = 2'h2;
  localparam logic [1:0] GAIN_40 = 2'h3;

  // ==========================================================
  // AHB-Lite encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [31:0] RDATA_ZERO = 32'h00000000;

  // ==========================================================
  // Calibration sequence
  typedef enum logic [1:0] {
    SAC_CAL_IDLE,
    SAC_CAL_TRIM,
    SAC_CAL_HOLD
  } sac_cal_e;

endpackage

// ===== core/sac_phase.sv
`timescale 1ns/1ps
`default_nettype none
module sac_phase (
  input wire logic hclk,                             // Clock
  input wire logic hresetn,                          // Async reset, low
  input wire logic ls_cmd,                           // Low-side gate command
  input wire logic hs_cmd,                           // High-side gate command
  input wire logic [sac_pkg::CNT_W-1:0] drive_cycles, // Drive window length
  input wire logic [sac_pkg::CNT_W-1:0] cal_cycles,  // Trim routine length
  input wire logic fet_mode,                         // Transistor voltage sensing
  input wire logic cal_req,                          // Calibration request level
  input wire logic [1:0] gain_prog,                  // Programmed gain code
  output logic [1:0] gain_eff,                       // Gain applied to amplifier
  output logic amp_enable,                           // Amplifier enabled
  output logic in_short,                             // Inputs shorted together
  output logic load_disc,                            // Load disconnected
  output logic pos_to_switch,                        // Positive input on switch node
  output logic trim_run,                             // Trim routine running
  output logic trim_done,                            // Trim finished, still held
  output logic window_active                         // Drive window open
);

  // ==========================================================
  // State
  logic ls_q_reg, ls_q_next;
  logic hs_q_reg, hs_q_next;
  logic [sac_pkg::CNT_W-1:0] win_cnt_reg, win_cnt_next;
  logic win_reg, win_next;
  logic fet_conn_reg, fet_conn_next;
  sac_pkg::sac_cal_e cal_reg, cal_next;
  logic [sac_pkg::CNT_W-1:0] cal_cnt_reg, cal_cnt_next;
  logic [1:0] gain_next;
  logic en_next, short_next, disc_next, pos_next;
  logic cmd_change, win_end, ls_fall, cal_on;

  // ==========================================================
  // Next state
  always_comb begin
    ls_q_next = ls_cmd;
    hs_q_next = hs_cmd;
    cmd_change = (ls_cmd != ls_q_reg) || (hs_cmd != hs_q_reg);
    ls_fall = ls_q_reg && !ls_cmd;
    win_end = win_reg && !cmd_change && (win_cnt_reg <= 16'h0001);
    win_next = win_reg;
    win_cnt_next = win_cnt_reg;
    // A new command restarts the window, cutting the old one short
    if (cmd_change) begin
      win_next = 1'b1;
      win_cnt_next = drive_cycles;
    end else if (win_end) begin
      win_next = 1'b0;
      win_cnt_next = '0;
    end else if (win_reg) begin
      win_cnt_next = win_cnt_reg - 16'h0001;
    end

    fet_conn_next = fet_conn_reg;
    if (!fet_mode) begin
      fet_conn_next = 1'b0;
    end else if (ls_fall) begin
      fet_conn_next = 1'b0;
    end else if (win_end && ls_cmd) begin
      fet_conn_next = 1'b1;
    end

    cal_next = cal_reg;
    cal_cnt_next = cal_cnt_reg;
    case (cal_reg)
      sac_pkg::SAC_CAL_IDLE: begin
        if (cal_req) begin
          cal_next = sac_pkg::SAC_CAL_TRIM;
          cal_cnt_next = cal_cycles;
        end
      end
      sac_pkg::SAC_CAL_TRIM: begin
        if (!cal_req) begin
          cal_next = sac_pkg::SAC_CAL_IDLE;
        end else if (cal_cnt_reg <= 16'h0001) begin
          cal_next = sac_pkg::SAC_CAL_HOLD;
          cal_cnt_next = '0;
        end else begin
          cal_cnt_next = cal_cnt_reg - 16'h0001;
        end
      end
      sac_pkg::SAC_CAL_HOLD: begin
        if (!cal_req) begin
          cal_next = sac_pkg::SAC_CAL_IDLE;
        end
      end
      default: begin
        cal_next = sac_pkg::SAC_CAL_IDLE;
      end
    endcase

    cal_on = (cal_next != sac_pkg::SAC_CAL_IDLE);
    // Calibration overrides every sensing mode while requested
    gain_next = cal_on ? sac_pkg::GAIN_40 : gain_prog;
    disc_next = cal_on;
    short_next = cal_on || (fet_mode && !fet_conn_next);
    pos_next = fet_mode && !cal_on;
    en_next = cal_on || !fet_mode || fet_conn_next;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ls_q_reg <= 1'b0;
      hs_q_reg <= 1'b0;
      win_reg <= 1'b0;
      win_cnt_reg <= '0;
      fet_conn_reg <= 1'b0;
      cal_reg <= sac_pkg::SAC_CAL_IDLE;
      cal_cnt_reg <= '0;
      gain_eff <= sac_pkg::GAIN_5;
      amp_enable <= 1'b1;
      in_short <= 1'b0;
      load_disc <= 1'b0;
      pos_to_switch <= 1'b0;
      trim_run <= 1'b0;
      trim_done <= 1'b0;
      window_active <= 1'b0;
    end else begin
      ls_q_reg <= ls_q_next;
      hs_q_reg <= hs_q_next;
      win_reg <= win_next;
      win_cnt_reg <= win_cnt_next;
      fet_conn_reg <= fet_conn_next;
      cal_reg <= cal_next;
      cal_cnt_reg <= cal_cnt_next;
      gain_eff <= gain_next;
      amp_enable <= en_next;
      in_short <= short_next;
      load_disc <= disc_next;
      pos_to_switch <= pos_next;
      trim_run <= (cal_next == sac_pkg::SAC_CAL_TRIM);
      trim_done <= (cal_next == sac_pkg::SAC_CAL_HOLD);
      window_active <= win_next;
    end
  end

endmodule
`default_nettype wire

// ===== dv/sac_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Motor controller model: drives the gate commands and the calibration pin
module sac_ctrl_model #(
  parameter int HALF = 12
) (
  input wire logic hclk,               // Clock
  input wire logic hresetn,            // Reset, low
  input wire logic sw_en,              // Bridge switching wanted
  input wire logic cal_want,           // Calibration wanted
  output logic [2:0] ls_gate_cmd,      // Low-side commands
  output logic [2:0] hs_gate_cmd,      // High-side commands
  output logic cal_pin                 // Calibration request
);
  int cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 0;
      ls_gate_cmd <= 3'h0;
      hs_gate_cmd <= 3'h0;
      cal_pin <= 1'b0;
    end else begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      // Bridge parked with both sides off whenever switching is not wanted
      if (!sw_en) begin
        ls_gate_cmd <= 3'h0;
        hs_gate_cmd <= 3'h0;
      end else if (cnt == HALF - 1) begin
        ls_gate_cmd <= ~ls_gate_cmd;
        hs_gate_cmd <= ls_gate_cmd;
      end
      // Calibration only asked for on an idle bridge; dropping the level ends it
      cal_pin <= cal_want && !sw_en;
    end
  end
endmodule
`default_nettype wire

// ===== dv/sac_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker on the top-level ports
module sac_top_chk #(
  parameter int unsigned CAL_CYCLES = 20
) (
  input wire logic hclk,                        // Clock
  input wire logic hresetn,                     // Reset, low
  input wire logic hreadyout,                   // Slave ready
  input wire logic hresp,                       // Response
  input wire logic cal_pin,                     // Calibration pin
  input wire logic [2:0] ls_gate_cmd,           // Low-side commands
  input wire logic [5:0] amp_gain,              // Gain codes
  input wire logic lowside_ref_neg,             // Monitor reference
  input wire logic [2:0] amp_enable,            // Enables
  input wire logic [2:0] amp_in_short,          // Inputs shorted
  input wire logic [2:0] amp_load_disc,         // Load off
  input wire logic [2:0] amp_pos_switch_node,   // Positive input source
  input wire logic [2:0] amp_trim_run           // Trim running
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic [15:0] trim_cnt_reg;
  logic [15:0] trim_cnt_next;
  always_comb begin
    trim_cnt_next = amp_trim_run[0] ? trim_cnt_reg + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trim_cnt_reg <= 16'h0000;
    end else begin
      trim_cnt_reg <= trim_cnt_next;
    end
  end

  property p_hresp;
    hresp == 1'b0;
  endproperty
  a_hresp: assert property (p_hresp) else $error("error response seen");
  property p_rd_one;
    !hreadyout |=> hreadyout;
  endproperty
  a_rd_one: assert property (p_rd_one) else $error("wait state too long");
  property p_cal_gain;
    cal_pin |=> amp_gain == 6'h3F;
  endproperty
  a_cal_gain: assert property (p_cal_gain) else $error("gain not forced");
  property p_cal_short;
    cal_pin |=> (&amp_in_short) && (&amp_load_disc) && amp_pos_switch_node == 3'h0;
  endproperty
  a_cal_short: assert property (p_cal_short) else $error("inputs not isolated");
  property p_trim_bound;
    trim_cnt_reg <= CAL_CYCLES;
  endproperty
  a_trim_bound: assert property (p_trim_bound) else $error("trim too long");
  property p_hold;
    $fell(amp_trim_run[0]) && cal_pin |-> amp_gain[1:0] == 2'h3 && amp_load_disc[0];
  endproperty
  a_hold: assert property (p_hold) else $error("setup dropped after trim");
  property p_fet_ref;
    |amp_pos_switch_node |-> lowside_ref_neg;
  endproperty
  a_fet_ref: assert property (p_fet_ref) else $error("monitor reference wrong");
  property p_fet_excl;
    amp_pos_switch_node[0] |-> amp_enable[0] != amp_in_short[0];
  endproperty
  a_fet_excl: assert property (p_fet_excl) else $error("enable and short clash");
  property p_fet_off;
    amp_pos_switch_node[0] && $fell(ls_gate_cmd[0]) |=> amp_in_short[0] && !amp_enable[0];
  endproperty
  a_fet_off: assert property (p_fet_off) else $error("no short at turn-off");
endmodule

bind sac_top sac_top_chk #(.CAL_CYCLES(CAL_CYCLES)) i_sac_top_chk (.hclk, .hresetn, .hreadyout,
  .hresp, .cal_pin, .ls_gate_cmd, .amp_gain, .lowside_ref_neg, .amp_enable, .amp_in_short,
  .amp_load_disc, .amp_pos_switch_node, .amp_trim_run);
`default_nettype wire

// ===== dv/sac_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sac_top_tb_top;
  localparam int CAL = 20;
  // Row: ctrl, gain, bypass, ref_neg, pos_switch
  localparam logic [18:0] ROWS [8] = '{{8'h00, 6'h00, 5'h00}, {8'h01, 6'h15, 5'h00},
    {8'h02, 6'h2A, 5'h00}, {8'h03, 6'h3F, 5'h00}, {8'h04, 6'h00, 5'h10},
    {8'h10, 6'h00, 5'h08}, {8'h08, 6'h00, 5'h0F}, {8'h1A, 6'h2A, 5'h0F}};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, vref_div_bypass, lowside_ref_neg, cal_pin;
  logic sw_en, cal_want;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize, ls_gate_cmd, hs_gate_cmd, amp_enable, amp_in_short, amp_load_disc;
  logic [2:0] amp_pos_switch_node, amp_trim_run;
  logic [5:0] amp_gain;
  int num_errors = 0;
  int n_compared = 0;
  int n;

  always #2 hclk = ~hclk;

  sac_top #(.CAL_CYCLES(CAL)) i_sac_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .cal_pin, .ls_gate_cmd,
    .hs_gate_cmd, .amp_gain, .vref_div_bypass, .lowside_ref_neg, .amp_enable, .amp_in_short,
    .amp_load_disc, .amp_pos_switch_node, .amp_trim_run);
  sac_ctrl_model i_sac_ctrl_model (.hclk, .hresetn, .sw_en, .cal_want, .ls_gate_cmd,
    .hs_gate_cmd, .cal_pin);

  // ==========================================================
  // Tasks
  task automatic tick(input int k);
    repeat (k) @(posedge hclk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One single AHB transfer; read data lands in q
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h00000, a};
    hsize <= sac_pkg::HSIZE_WORD;
    while (hreadyout !== 1'b1) tick(1);
    tick(1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    while (hreadyout !== 1'b1) tick(1);
    q = hrdata;
    tick(1);
  endtask

  task automatic wait_ls(input logic v);
    n = 0;
    while (ls_gate_cmd[0] !== v && n < 50) begin
      n++;
      tick(1);
    end
    chk("ls_wait", 32'(ls_gate_cmd[0]), 32'(v));
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end

  // ==========================================================
  // Tests
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    sw_en = 1'b0;
    cal_want = 1'b0;
    tick(5);
    hresetn <= 1'b1;
    tick(1);
    chk("enable", 32'(amp_enable), 32'h7);
    bus(1'b0, sac_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl", q, 32'h0);
    bus(1'b0, sac_pkg::ADDR_TDRIVE, 32'h0);
    chk("tdrive", q, 32'h3E8);
    bus(1'b0, 12'h00C, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, sac_pkg::ADDR_CTRL, 32'(ROWS[i][18:11]));
      tick(1);
      chk("gain", 32'(amp_gain), 32'(ROWS[i][10:5]));
      chk("bypass", 32'(vref_div_bypass), 32'(ROWS[i][4]));
      chk("ref_neg", 32'(lowside_ref_neg), 32'(ROWS[i][3]));
      chk("pos_switch", 32'(amp_pos_switch_node), 32'(ROWS[i][2:0]));
      bus(1'b0, sac_pkg::ADDR_CTRL, 32'h0);
      chk("ctrl", q, 32'(ROWS[i][18:11]));
    end
    $display("mode table test done");
    // Phase 1 only, by register bit, while phase 0 keeps gain 10
    bus(1'b1, sac_pkg::ADDR_CTRL, 32'h41);
    n = 0;
    while (amp_trim_run[1] !== 1'b1 && n < 5) begin
      n++;
      tick(1);
    end
    chk("cal_gain", 32'(amp_gain), 32'h1D);
    chk("cal_short", 32'({amp_in_short, amp_load_disc}), 32'h12);
    n = 0;
    while (amp_trim_run[1] === 1'b1 && n < 100) begin
      n++;
      tick(1);
    end
    chk("trim_cycles", n, CAL);
    bus(1'b0, sac_pkg::ADDR_STATUS, 32'h0);
    chk("trim_done", 32'(q[5:3]), 32'h2);
    chk("hold_gain", 32'(amp_gain), 32'h1D);
    bus(1'b1, sac_pkg::ADDR_CTRL, 32'h01);
    tick(1);
    chk("restore", 32'({amp_gain, amp_in_short, amp_load_disc}), 32'h540);
    $display("register calibration test done");
    cal_want <= 1'b1;
    tick(4);
    chk("pin_cal", 32'({amp_gain, amp_load_disc}), 32'h1FF);
    tick(30);
    chk("pin_hold", 32'({amp_gain, amp_trim_run}), 32'h1F8);
    cal_want <= 1'b0;
    tick(3);
    chk("pin_restore", 32'({amp_gain, amp_load_disc}), 32'h0A8);
    $display("pin calibration test done");
    bus(1'b1, sac_pkg::ADDR_TDRIVE, 32'h4);
    bus(1'b1, sac_pkg::ADDR_CTRL, 32'h08);
    sw_en <= 1'b1;
    wait_ls(1'b1);
    tick(2);
    chk("win_open", 32'({amp_enable[0], amp_in_short[0]}), 32'h1);
    tick(8);
    chk("win_end", 32'({amp_enable[0], amp_in_short[0]}), 32'h2);
    wait_ls(1'b0);
    tick(1);
    chk("ls_off", 32'({amp_enable[0], amp_in_short[0]}), 32'h1);
    sw_en <= 1'b0;
    tick(3);
    bus(1'b1, sac_pkg::ADDR_CTRL, 32'h0);
    $display("transistor sense test done");
    // Reset in mid-calibration must drop every override at once
    bus(1'b1, sac_pkg::ADDR_CTRL, 32'h35);
    tick(2);
    chk("pre_rst", 32'({amp_gain, amp_trim_run, vref_div_bypass, lowside_ref_neg}), 32'h2E7);
    hresetn <= 1'b0;
    tick(1);
    chk("rst_mid", 32'({amp_gain, amp_enable, amp_trim_run, amp_load_disc}), 32'h1C0);
    chk("rst_vref", 32'({vref_div_bypass, lowside_ref_neg}), 32'h0);
    hresetn <= 1'b1;
    tick(2);
    chk("rst_after", 32'({amp_gain, amp_enable, amp_trim_run, amp_load_disc}), 32'h1C0);
    bus(1'b0, sac_pkg::ADDR_CTRL, 32'h0);
    chk("rst_ctrl", q, 32'h0);
    bus(1'b0, sac_pkg::ADDR_TDRIVE, 32'h0);
    chk("rst_tdrive", q, 32'h3E8);
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
